// ==== npm_consts.svh ====
// Constants of the notebook power manager: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design, checker and bench files.
`ifndef NPM_CONSTS_SVH
`define NPM_CONSTS_SVH
`define NPM_ADDR_CTRL 8'h00
`define NPM_ADDR_STATUS 8'h04
`define NPM_ADDR_SCHED 8'h08
`define NPM_ADDR_VIDTMR 8'h0c
`define NPM_ADDR_FLAGS 8'h10
// Control register fields
`define NPM_C_FLOPPY 0
`define NPM_C_SERIAL 1
`define NPM_C_IR 2
`define NPM_C_PAR 3
`define NPM_C_FDPAR 4
`define NPM_C_MODEM 5
`define NPM_C_CPUSTOP 6
`define NPM_C_RING 7
`define NPM_C_GOMEM 8
`define NPM_C_GODISK 9
`define NPM_C_SCHED 10
`define NPM_C_OPTICAL 12
`define NPM_C_HDD 13
`define NPM_CTRL_RST 14'h302f
`define NPM_VIDTMR_RST 32'h0000ffff
// Flag register fields
`define NPM_F_MODEMLOST 0
`define NPM_F_RESUMED 1
// Thermal thresholds in degrees C
`define NPM_CPU_THROTTLE 8'h50
`define NPM_CPU_SHUTDOWN 8'h5f
`define NPM_CPU_NORMAL 8'h4b
`define NPM_SYS_FULL 8'h38
`define NPM_SYS_TRICKLE 8'h3a
`define NPM_SYS_SHUTDOWN 8'h55
// Drive reset hold time
`define NPM_CLK_MHZ 100
`define NPM_DRV_RST_NS 1000
`define NPM_DRV_RST_CYC ((`NPM_DRV_RST_NS * `NPM_CLK_MHZ + 999) / 1000)
`endif

// ==== npm_pkg.sv ====
// Types of the notebook power manager.
// Assumes nothing beyond a SystemVerilog compiler.
package npm_pkg;
  // System suspend sequencer states
  typedef enum logic [5:0] {
    ST_RUN = 6'b000001,
    ST_DOWN = 6'b000010,
    ST_STR = 6'b000100,
    ST_STD = 6'b001000,
    ST_CHECK = 6'b010000,
    ST_WAKE = 6'b100000
  } npm_state_t;
  // Removable drive power sequence states
  typedef enum logic [3:0] {
    DR_OFF = 4'b0001,
    DR_RESET = 4'b0010,
    DR_ON = 4'b0100,
    DR_ISO = 4'b1000
  } npm_drive_t;
endpackage

// ==== npm_power_manager.sv ====
// Notebook power manager: peripheral power sequencing, thermal control,
// suspend to memory and disk, resume evaluation, APB register access.
// Assumes inputs synchronous to ref_clk and an APB master.
`include "npm_consts.svh"
module npm_power_manager #(
  parameter int VID_TMR_W = 16, // Video inactivity timer width
  parameter int DRV_RST_CYC = `NPM_DRV_RST_CYC // Drive reset hold
) (
  input wire logic ref_clk, // System clock, 100 MHz
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic [7:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic ps2KeyActivity, // PS/2 keyboard activity
  input wire logic ps2MouseActivity, // PS/2 mouse activity
  input wire logic internalKeystroke, // Internal keyboard key
  input wire logic primaryKeystroke, // Primary PS/2 port key
  input wire logic lidOpen, // Lid switch, high when open
  input wire logic batteryVeryLow, // Battery very low level
  input wire logic busHoldAck, // Bus masters and DMA halted
  input wire logic cpuThermalAlarmN, // CPU thermal alarm, low
  input wire logic [7:0] cpuTemp, // CPU temperature, deg C
  input wire logic [7:0] systemThermalInput, // System temp, deg C
  input wire logic [15:0] rtcTime, // Current time of day
  input wire logic [15:0] rtcDate, // Current date
  output logic driveBufferIsolate, // Drive buffer isolated
  output logic removableDrivePowerOn, // Optical and floppy power
  output logic driveResetN, // Optical drive reset, low
  output logic hddPowerOn, // Hard disk power
  output logic floppyControllerDecode, // Floppy decode enable
  output logic floppyPllEnable, // Floppy controller PLL
  output logic videoPowerDown, // Video suspend
  output logic firstSerialDecode, // First serial decode
  output logic firstSerialOutEnable, // First serial outputs
  output logic serialTransceiverPowerDownN, // Transceiver, low
  output logic ringResumeEnable, // Ring pass-through wanted
  output logic secondSerialOutEnable, // Infrared outputs
  output logic clk14Enable, // Shared 14 MHz clock
  output logic parallelDecode, // Parallel port decode
  output logic modemPowerOnN, // Modem power, low
  output logic modemClockEnable, // Modem dedicated clocks
  output logic busHoldReq, // Halt bus masters and DMA
  output logic cpuClockStop, // CPU clock stopped
  output logic cpuThrottle, // CPU clock throttling
  output logic fullCharge, // Full battery charging
  output logic trickleCharge, // Trickle battery charging
  output logic systemShutdown, // Thermal shutdown
  output logic clockGenEnable, // Clock generator enable
  output logic systemPowerOn, // Main machine power
  output logic [4:0] lowPowerForce, // Audio,xcvr,ir,kbc,card
  output logic smiRequest // SMI request, level while in memory suspend with battery very low
);
  ////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (VID_TMR_W < 1 || VID_TMR_W > 32) begin : g_chk_w
    $error("VID_TMR_W must be 1 to 32");
  end
  if (DRV_RST_CYC < 1 || DRV_RST_CYC > 255) begin : g_chk_r
    $error("DRV_RST_CYC must be 1 to 255");
  end
  // Address match shared by write and read decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction
  ////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [13:0] ctrl; // Control bits
  logic [31:0] sched; // Date high, time low
  logic [31:0] vidReload; // Video timer reload
  logic [1:0] flags; // Sticky flags
  npm_pkg::npm_state_t state; // Suspend sequencer
  npm_pkg::npm_state_t next_state; // Next sequencer state
  npm_pkg::npm_drive_t drive; // Drive power sequence
  npm_pkg::npm_drive_t next_drive; // Next drive state
  logic [7:0] rstCnt; // Drive reset hold count
  logic [1:0] serialLvl; // 3 full on, 0 fully down
  logic irLvl; // Infrared outputs on
  logic [VID_TMR_W-1:0] vidCnt; // Video inactivity count
  logic diskMode; // Current suspend targets disk
  logic lidPrev; // Lid level last cycle
  logic modemPrev; // Modem power last cycle
  ////////////////////////////////////////////////////////////////////
  // APB decode
  wire setup = psel & ~penable; // First cycle of transfer
  wire access = psel & penable; // Access phase
  wire wrEn = access & pwrite; // Write takes effect
  wire hitCtrl = hit(paddr, `NPM_ADDR_CTRL);
  wire hitStat = hit(paddr, `NPM_ADDR_STATUS);
  wire hitSched = hit(paddr, `NPM_ADDR_SCHED);
  wire hitVid = hit(paddr, `NPM_ADDR_VIDTMR);
  wire hitFlags = hit(paddr, `NPM_ADDR_FLAGS);
  wire mapped = hitCtrl | hitStat | hitSched | hitVid | hitFlags;
  assign pready = access; // No wait states
  assign pslverr = access & ~mapped; // Unmapped address answer
  wire wrCtrl = wrEn & hitCtrl;
  ////////////////////////////////////////////////////////////////////
  // Derived conditions
  wire run = (state == npm_pkg::ST_RUN);
  wire goMem = wrCtrl & pwdata[`NPM_C_GOMEM];
  wire diskOk = ~(ctrl[`NPM_C_SCHED] | pwdata[`NPM_C_SCHED]) |
                batteryVeryLow;
  wire goDisk = wrCtrl & pwdata[`NPM_C_GODISK] & diskOk;
  wire lidRise = lidOpen & ~lidPrev;
  wire keyWake = internalKeystroke | primaryKeystroke;
  wire timeMatch = ctrl[`NPM_C_SCHED] & (rtcTime == sched[15:0]);
  wire dateFuture = sched[31:16] > rtcDate;
  wire driveWant = run & (ctrl[`NPM_C_FLOPPY] | ctrl[`NPM_C_OPTICAL]);
  wire serialWant = run & ctrl[`NPM_C_SERIAL];
  wire irWant = run & ctrl[`NPM_C_IR];
  wire floppyOn = removableDrivePowerOn & ctrl[`NPM_C_FLOPPY];
  wire clkNeed = floppyOn | (serialLvl != 2'h0) | irLvl;
  wire allLow = (drive == npm_pkg::DR_OFF) & (serialLvl == 2'h0) &
                ~irLvl & ~clk14Enable & videoPowerDown & cpuClockStop;
  wire vidRetrig = ps2KeyActivity | ps2MouseActivity;
  ////////////////////////////////////////////////////////////////////
  // Suspend sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      npm_pkg::ST_RUN: // Suspend request starts shutdown
        if ((goMem | goDisk) & ~systemShutdown)
          next_state = npm_pkg::ST_DOWN;
      npm_pkg::ST_DOWN: // Wait for all low power
        if (allLow)
          next_state = diskMode ? npm_pkg::ST_STD : npm_pkg::ST_STR;
      npm_pkg::ST_STR: // Memory suspend wake events
        if (lidRise | keyWake)
          next_state = npm_pkg::ST_WAKE;
        else if (timeMatch & dateFuture)
          next_state = npm_pkg::ST_CHECK;
        else if (timeMatch)
          next_state = npm_pkg::ST_WAKE;
      npm_pkg::ST_STD: // Only lid opening leaves
        if (lidRise)
          next_state = npm_pkg::ST_WAKE;
      npm_pkg::ST_CHECK: // Date check, then back down
        if (~timeMatch)
          next_state = npm_pkg::ST_STR;
      npm_pkg::ST_WAKE: next_state = npm_pkg::ST_RUN;
      default: next_state = npm_pkg::ST_RUN;
    endcase
  end
  // Sequencer state and suspend target
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= npm_pkg::ST_RUN;
      diskMode <= 1'b0;
      lidPrev <= 1'b0;
    end else begin
      state <= next_state;
      lidPrev <= lidOpen;
      if (run & (goMem | goDisk))
        diskMode <= goDisk;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Removable drive power sequence
  always_comb begin
    next_drive = drive;
    case (drive)
      npm_pkg::DR_OFF: // Power up with reset held
        if (driveWant)
          next_drive = npm_pkg::DR_RESET;
      npm_pkg::DR_RESET: // Buffer after reset time
        if (rstCnt == 8'h00)
          next_drive = npm_pkg::DR_ON;
      npm_pkg::DR_ON: // Isolate before power off
        if (~driveWant)
          next_drive = npm_pkg::DR_ISO;
      npm_pkg::DR_ISO: next_drive = npm_pkg::DR_OFF;
      default: next_drive = npm_pkg::DR_OFF;
    endcase
  end
  // Drive state and reset counter
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive <= npm_pkg::DR_OFF;
      rstCnt <= 8'h00;
    end else begin
      drive <= next_drive;
      if (drive != npm_pkg::DR_RESET)
        rstCnt <= 8'(DRV_RST_CYC - 1);
      else if (rstCnt != 8'h00)
        rstCnt <= rstCnt - 8'h01;
    end
  end
  // Drive pins follow the sequence
  assign removableDrivePowerOn = (drive != npm_pkg::DR_OFF);
  assign driveResetN = (drive == npm_pkg::DR_ON);
  assign driveBufferIsolate = (drive != npm_pkg::DR_ON);
  assign floppyControllerDecode = floppyOn;
  assign floppyPllEnable = clkNeed;
  ////////////////////////////////////////////////////////////////////
  // Serial and infrared stepping; clock follows one cycle late
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      serialLvl <= 2'h3;
      irLvl <= 1'b1;
      clk14Enable <= 1'b1;
    end else begin
      clk14Enable <= clkNeed | serialWant | irWant |
                     (run & ctrl[`NPM_C_FLOPPY]);
      // Down one step a cycle; up only with clock running
      if (~serialWant & serialLvl != 2'h0)
        serialLvl <= serialLvl - 2'h1;
      else if (serialWant & clk14Enable & serialLvl != 2'h3)
        serialLvl <= serialLvl + 2'h1;
      if (~irWant)
        irLvl <= 1'b0;
      else if (clk14Enable)
        irLvl <= 1'b1;
    end
  end
  // Serial pins from the step level, ring enable from control
  assign firstSerialDecode = (serialLvl == 2'h3);
  assign firstSerialOutEnable = (serialLvl >= 2'h2);
  assign serialTransceiverPowerDownN = (serialLvl != 2'h0);
  assign ringResumeEnable = ctrl[`NPM_C_RING];
  assign secondSerialOutEnable = irLvl;
  // Parallel port: decode only, held for floppy use
  assign parallelDecode = ctrl[`NPM_C_PAR] | ctrl[`NPM_C_FDPAR];
  ////////////////////////////////////////////////////////////////////
  // Video inactivity timer, PS/2 retriggered only
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      vidCnt <= '1;
    else if (vidRetrig)
      vidCnt <= vidReload[VID_TMR_W-1:0];
    else if (vidCnt != '0)
      vidCnt <= vidCnt - 1'b1;
  end
  assign videoPowerDown = (vidCnt == '0) | ~run;
  ////////////////////////////////////////////////////////////////////
  // Modem, CPU clock and suspend-wide outputs
  assign modemPowerOnN = ~ctrl[`NPM_C_MODEM];
  assign modemClockEnable = ctrl[`NPM_C_MODEM];
  assign busHoldReq = ctrl[`NPM_C_CPUSTOP] | ~run;
  assign clockGenEnable = (state != npm_pkg::ST_STR);
  assign systemPowerOn = (state != npm_pkg::ST_STD) & ~systemShutdown;
  assign hddPowerOn = ctrl[`NPM_C_HDD] &
                      (run | (state == npm_pkg::ST_DOWN & diskMode));
  // Force listed devices low at suspend start
  genvar gi;
  for (gi = 0; gi < 5; gi++) begin : g_force
    assign lowPowerForce[gi] = ~run;
  end
  // Hold wanted next cycle
  wire holdNext = (next_state != npm_pkg::ST_RUN) |
                  (wrCtrl ? pwdata[`NPM_C_CPUSTOP] : ctrl[`NPM_C_CPUSTOP]);
  // CPU clock stop waits for bus hold acknowledge
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      cpuClockStop <= 1'b0;
    else
      cpuClockStop <= holdNext & busHoldReq & busHoldAck;
  end
  ////////////////////////////////////////////////////////////////////
  // Thermal control with hysteresis
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpuThrottle <= 1'b0;
      fullCharge <= 1'b1;
      trickleCharge <= 1'b0;
      systemShutdown <= 1'b0;
    end else begin
      // CPU alarm throttles, clears at normal level
      if (~cpuThermalAlarmN & cpuTemp > `NPM_CPU_THROTTLE)
        cpuThrottle <= 1'b1;
      else if (cpuTemp <= `NPM_CPU_NORMAL)
        cpuThrottle <= 1'b0;
      // Charger mode from system temperature
      if (systemThermalInput < `NPM_SYS_FULL) begin
        fullCharge <= 1'b1;
        trickleCharge <= 1'b0;
      end else if (systemThermalInput > `NPM_SYS_TRICKLE) begin
        fullCharge <= 1'b0;
        trickleCharge <= 1'b1;
      end
      // Shutdown holds until reset
      if ((~cpuThermalAlarmN & cpuTemp > `NPM_CPU_SHUTDOWN) |
          (systemThermalInput > `NPM_SYS_SHUTDOWN))
        systemShutdown <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Register writes, sticky flags and SMI
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= `NPM_CTRL_RST;
      sched <= 32'h00000000;
      vidReload <= `NPM_VIDTMR_RST;
      flags <= 2'h0;
      modemPrev <= 1'b1;
      smiRequest <= 1'b0;
    end else begin
      modemPrev <= ctrl[`NPM_C_MODEM];
      smiRequest <= (state == npm_pkg::ST_STR) & batteryVeryLow;
      if (wrCtrl)
        ctrl <= pwdata[13:0] & 14'h3cff;
      if (wrEn & hitSched)
        sched <= pwdata;
      if (wrEn & hitVid)
        vidReload <= pwdata;
      // Schedule disables itself after a real resume
      if (state == npm_pkg::ST_STR & timeMatch & ~dateFuture)
        ctrl[`NPM_C_SCHED] <= 1'b0;
      // Write one clears; a new event wins
      if (wrEn & hitFlags)
        flags <= flags & ~pwdata[1:0];
      if (modemPrev & ~ctrl[`NPM_C_MODEM])
        flags[`NPM_F_MODEMLOST] <= 1'b1;
      if (state == npm_pkg::ST_WAKE)
        flags[`NPM_F_RESUMED] <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Read data captured in the setup cycle
  wire [31:0] statusWord = {8'h00, serialLvl, irLvl, clk14Enable,
                            drive, 2'h0, state, diskMode, systemShutdown,
                            cpuThrottle, cpuClockStop, fullCharge,
                            trickleCharge, videoPowerDown,
                            removableDrivePowerOn};
  wire [31:0] rdMux = hitCtrl ? {18'h00000, ctrl} :
                      hitStat ? statusWord :
                      hitSched ? sched :
                      hitVid ? vidReload :
                      hitFlags ? {30'h00000000, flags} : 32'h00000000;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      prdata <= 32'h00000000;
    else if (setup & ~pwrite)
      prdata <= rdMux;
  end
endmodule

// ==== npm_power_manager_checker.sv ====
// Port-level assertions of the power manager.
// Assumes the bind below and the constants header.
`include "npm_consts.svh"
module npm_power_manager_checker (
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic busHoldAck, // Masters halted
  input wire logic cpuThermalAlarmN, // Alarm, low
  input wire logic [7:0] cpuTemp, // CPU deg C
  input wire logic [7:0] systemThermalInput, // System deg C
  input wire logic driveBufferIsolate, // Buffer isolated
  input wire logic removableDrivePowerOn, // Drive power
  input wire logic driveResetN, // Drive reset, low
  input wire logic floppyControllerDecode, // Floppy decode
  input wire logic floppyPllEnable, // Floppy PLL
  input wire logic firstSerialDecode, // Serial decode
  input wire logic firstSerialOutEnable, // Serial outputs
  input wire logic serialTransceiverPowerDownN, // Transceiver
  input wire logic secondSerialOutEnable, // Infrared outputs
  input wire logic clk14Enable, // Shared clock
  input wire logic busHoldReq, // Halt request
  input wire logic cpuClockStop, // CPU clock stop
  input wire logic cpuThrottle, // Throttle
  input wire logic fullCharge, // Full charge
  input wire logic trickleCharge, // Trickle charge
  input wire logic systemShutdown, // Shutdown
  input wire logic clockGenEnable, // Clock generator
  input wire logic modemClockEnable, // Modem clocks
  input wire logic [4:0] lowPowerForce // Forced low power
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  a_floppy_tristate: assert property (!removableDrivePowerOn |->
    driveBufferIsolate) else $error("pins live");
  a_buffer_reenable: assert property (!driveBufferIsolate |->
    removableDrivePowerOn && driveResetN) else $error("buffer early");
  a_isolate_first: assert property ($fell(removableDrivePowerOn) |->
    $past(driveBufferIsolate)) else $error("not isolated");
  a_pll_idle: assert property (!floppyPllEnable |->
    !floppyControllerDecode && !firstSerialDecode
    && !secondSerialOutEnable) else $error("PLL off");
  a_serial_order: assert property (firstSerialDecode |->
    firstSerialOutEnable && serialTransceiverPowerDownN && clk14Enable)
    else $error("serial order");
  a_serial_step: assert property ($fell(firstSerialOutEnable) |->
    !$past(firstSerialDecode)) else $error("serial step");
  a_clock_last: assert property (!clk14Enable |->
    !serialTransceiverPowerDownN && !secondSerialOutEnable
    && !floppyControllerDecode) else $error("clock early");
  a_stop_halted: assert property (cpuClockStop |->
    busHoldReq && busHoldAck) else $error("bus live");
  a_throttle_on: assert property (!cpuThermalAlarmN &&
    cpuTemp > `NPM_CPU_THROTTLE |=> cpuThrottle) else $error("no throttle");
  a_throttle_off: assert property (cpuTemp <= `NPM_CPU_NORMAL
    |=> !cpuThrottle) else $error("throttle kept");
  a_cpu_shutdown: assert property (!cpuThermalAlarmN &&
    cpuTemp > `NPM_CPU_SHUTDOWN |=> systemShutdown) else $error("no off");
  a_full_charge: assert property (systemThermalInput < `NPM_SYS_FULL
    |=> fullCharge && !trickleCharge) else $error("full");
  a_trickle_mode: assert property (systemThermalInput > `NPM_SYS_TRICKLE
    |=> trickleCharge && !fullCharge) else $error("trickle");
  a_sys_shutdown: assert property (systemThermalInput >
    `NPM_SYS_SHUTDOWN |=> systemShutdown) else $error("no off");
  a_force_together: assert property (lowPowerForce == 5'h00 ||
    lowPowerForce == 5'h1f) else $error("split");
  a_str_ready: assert property (!clockGenEnable |->
    lowPowerForce == 5'h1f && !removableDrivePowerOn && !clk14Enable
    && modemClockEnable) else $error("early suspend");
  // Main scenarios reached
  c_throttle: cover property ($rose(cpuThrottle));
  c_suspend: cover property ($fell(clockGenEnable));
  c_serial_off: cover property ($fell(firstSerialDecode));
endmodule

bind npm_power_manager npm_power_manager_checker
  npm_power_manager_checker_inst (.*);

// ==== npm_far_side_model.sv ====
// Far side: bus masters, CPU thermal sensor, transceiver.
// Assumes one ref_clk domain.
module npm_far_side_model #(
  parameter int ACK_DLY = 3, // Halt acknowledge latency
  parameter logic [7:0] ALARM_C = 8'h46 // Sensor trip point
) (
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic busHoldReq, // Halt request
  input wire logic [7:0] cpuTemp, // Sensed temperature
  input wire logic serialTransceiverPowerDownN, // Transceiver
  input wire logic ringResumeEnable, // Ring wake wanted
  input wire logic ringLine, // Ring from the line
  output logic busHoldAck, // Masters halted
  output logic cpuThermalAlarmN, // Alarm, low
  output logic ringToHost // Ring towards the host
);
  timeunit 1ns;
  timeprecision 1ps;
  int holdCnt; // Cycles since request
  ////////////////////////////////////////////////////////////////
  // Masters drain, then acknowledge
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst || !busHoldReq) begin
      holdCnt <= 0;
      busHoldAck <= 1'b0;
    end else begin
      if (holdCnt < ACK_DLY) holdCnt <= holdCnt + 1;
      busHoldAck <= (holdCnt >= ACK_DLY);
    end
  end
  // Alarm low while hot
  always_ff @(posedge ref_clk) cpuThermalAlarmN <= !(cpuTemp > ALARM_C);
  // Ring passes in power-down if ring wake on
  assign ringToHost = ringLine &
    (serialTransceiverPowerDownN | ringResumeEnable);
endmodule

// ==== npm_power_manager_test.sv ====
// Bench: APB tasks and power manager scenarios.
// Assumes the design, far side model and constants header.
`include "npm_consts.svh"
module npm_power_manager_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, cpuTemp, systemThermalInput;
  logic [31:0] pwdata, prdata, rd;
  logic ps2KeyActivity, ps2MouseActivity, internalKeystroke;
  logic primaryKeystroke, lidOpen, batteryVeryLow, busHoldAck;
  logic cpuThermalAlarmN, driveBufferIsolate, removableDrivePowerOn;
  logic driveResetN, hddPowerOn, floppyControllerDecode, floppyPllEnable;
  logic videoPowerDown, firstSerialDecode, firstSerialOutEnable;
  logic serialTransceiverPowerDownN, ringResumeEnable, clk14Enable;
  logic secondSerialOutEnable, parallelDecode, modemPowerOnN;
  logic modemClockEnable, busHoldReq, cpuClockStop, cpuThrottle;
  logic fullCharge, trickleCharge, systemShutdown, clockGenEnable;
  logic systemPowerOn, smiRequest, ringLine, ringToHost;
  logic [4:0] lowPowerForce;
  logic [15:0] rtcTime, rtcDate;
  int n_fail, n_checks, cyc;
  npm_power_manager #(.DRV_RST_CYC(2)) npm_power_manager_inst (.*);
  npm_far_side_model npm_far_side_model_inst (.*);
  ////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic conclude;
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitBit(ref logic s, input logic v);
    #1;
    for (int i = 0; i < 300 && s !== v; i++) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  // Wait for a level, then compare it
  task automatic wchk(input string nm, ref logic s, input logic v);
    waitBit(s, v);
    chk(nm, {31'h0, v}, {31'h0, s});
  endtask
  task automatic drvIn(input int k, input logic v);
    case (k)
      0: internalKeystroke <= v;
      1: primaryKeystroke <= v;
      2: lidOpen <= v;
      3: ps2MouseActivity <= v;
      4: ps2KeyActivity <= v;
      default: batteryVeryLow <= v;
    endcase
  endtask
  task automatic pulse(input int k);
    @(posedge ref_clk);
    drvIn(k, 1'b1);
    @(posedge ref_clk);
    drvIn(k, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {ref_clk, psel, penable, pwrite, paddr, pwdata} = '0;
    {ps2KeyActivity, ps2MouseActivity, internalKeystroke} = '0;
    {primaryKeystroke, lidOpen, batteryVeryLow, ringLine} = '0;
    {cpuTemp, systemThermalInput} = 16'h2828;
    {rtcTime, rtcDate} = 32'h00000005;
    sys_rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Reset values, unmapped access, drive bring-up
    apb(1'b0, `NPM_ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h0000302f, rd);
    apb(1'b0, `NPM_ADDR_VIDTMR, 32'h0);
    chk("vidtmr", 32'h0000ffff, rd);
    apb(1'b0, 8'h14, 32'h0);
    chk("slverr", 32'h1, err);
    waitBit(driveBufferIsolate, 1'b0);
    chk("drvpwr", 32'h1, removableDrivePowerOn & driveResetN);
    $display("T1 done");
    // Floppy, serial, infrared down; serial back
    apb(1'b1, `NPM_ADDR_CTRL, 32'h00003028);
    wchk("clk14off", clk14Enable, 1'b0);
    chk("pll", 32'h0, floppyPllEnable);
    chk("xcvr", 32'h0, serialTransceiverPowerDownN);
    chk("irout", 32'h0, secondSerialOutEnable);
    apb(1'b1, `NPM_ADDR_CTRL, 32'h0000302a);
    waitBit(firstSerialDecode, 1'b1);
    chk("clk14", 32'h1, clk14Enable);
    chk("irstay", 32'h0, secondSerialOutEnable);
    $display("T2 done");
    // Parallel decode and floppy use through it, modem power
    apb(1'b1, `NPM_ADDR_CTRL, 32'h00003020);
    wchk("par", parallelDecode, 1'b0);
    apb(1'b1, `NPM_ADDR_CTRL, 32'h00003010);
    wchk("fdpar", parallelDecode, 1'b1);
    apb(1'b0, `NPM_ADDR_FLAGS, 32'h0);
    chk("lost", 32'h1, rd & 32'h1);
    apb(1'b1, `NPM_ADDR_FLAGS, 32'h1);
    apb(1'b1, `NPM_ADDR_CTRL, 32'h00003030);
    wchk("modem", modemPowerOnN, 1'b0);
    // Video timer, keyboard then mouse retrigger
    apb(1'b1, `NPM_ADDR_VIDTMR, 32'h4);
    pulse(4);
    wchk("vidoff", videoPowerDown, 1'b1);
    pulse(3);
    wchk("vidon", videoPowerDown, 1'b0);
    $display("T3 done");
    // Memory suspend; mouse ignored; key, key, lid wake
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `NPM_ADDR_CTRL, 32'h00003130);
      wchk("str", clockGenEnable, 1'b0);
      chk("hdd", 32'h0, hddPowerOn);
      chk("force", 32'h1f, lowPowerForce);
      chk("mclk", 32'h1, modemClockEnable);
      pulse(3);
      repeat (10) @(posedge ref_clk);
      #1;
      chk("mouse", 32'h0, clockGenEnable);
      drvIn(5, 1'b1);
      wchk("smi", smiRequest, 1'b1);
      drvIn(5, 1'b0);
      pulse(k);
      wchk("wake", clockGenEnable, 1'b1);
    end
    apb(1'b0, `NPM_ADDR_FLAGS, 32'h0);
    chk("resumed", 32'h2, rd & 32'h2);
    $display("T4 done");
    // Disk suspend: schedule blocks, low battery overrides
    apb(1'b1, `NPM_ADDR_CTRL, 32'h00003630);
    repeat (10) @(posedge ref_clk);
    #1;
    chk("block", 32'h1, systemPowerOn);
    drvIn(5, 1'b1);
    apb(1'b1, `NPM_ADDR_CTRL, 32'h00003630);
    wchk("std", systemPowerOn, 1'b0);
    drvIn(5, 1'b0);
    pulse(0);
    repeat (10) @(posedge ref_clk);
    #1;
    chk("stdkey", 32'h0, systemPowerOn);
    pulse(2);
    wchk("stdlid", systemPowerOn, 1'b1);
    $display("T5 done");
    // Scheduled wake with a past date, then self-disable
    apb(1'b1, `NPM_ADDR_SCHED, 32'h00010100);
    apb(1'b1, `NPM_ADDR_CTRL, 32'h00003530);
    waitBit(clockGenEnable, 1'b0);
    rtcTime <= 16'h0100;
    wchk("sched", clockGenEnable, 1'b1);
    rtcTime <= 16'h0000;
    apb(1'b0, `NPM_ADDR_CTRL, 32'h0);
    chk("selfoff", 32'h00003030, rd);
    $display("T6 done");
    // Thermal thresholds
    cpuTemp <= 8'h51;
    wchk("thr", cpuThrottle, 1'b1);
    cpuTemp <= 8'h4b;
    wchk("thrend", cpuThrottle, 1'b0);
    systemThermalInput <= 8'h3b;
    waitBit(trickleCharge, 1'b1);
    chk("trickle", 32'h0, fullCharge);
    systemThermalInput <= 8'h37;
    waitBit(fullCharge, 1'b1);
    chk("full", 32'h0, trickleCharge);
    systemThermalInput <= 8'h56;
    wchk("shut", systemShutdown, 1'b1);
    $display("T7 done");
    conclude();
  end
endmodule
